/* File: liu_maint_pkg.sv */
package liu_maint_pkg;

  // ----------------------------------------------------------------
  // register map (index; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] maintenance_control_six_idx = 8'h31;
  localparam logic [7:0] line_termination_config_idx = 8'h32;
  localparam logic [7:0] interrupt_mask_zero_idx = 8'h33;
  localparam logic [7:0] event_edge_select_idx = 8'h35;
  localparam logic [7:0] event_status_idx = 8'h36;
  localparam logic [7:0] event_pending_idx = 8'h37;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int violation_insert_bit = 6;
  localparam int pattern_error_insert_bit = 5;
  localparam int excess_zero_definition_bit = 4;
  localparam int counted_error_lsb = 2;
  localparam int counter_report_mode_bit = 1;
  localparam int counter_hold_bit = 0;
  localparam int tx_term_lsb = 3;
  localparam int rx_term_lsb = 0;
  localparam int num_events = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] maint_reset = 8'h00;
  localparam logic [7:0] term_reset = 8'h00;
  localparam logic [7:0] mask_reset = 8'h00;
  localparam logic [7:0] edge_reset = 8'h00;

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    count_prbs = 2'h0,
    count_exz = 2'h1,
    count_cv = 2'h2,
    count_cv_exz = 2'h3
  } counted_error_e;

  typedef enum logic [2:0] {
    term_75 = 3'h0,
    term_120 = 3'h1,
    term_100 = 3'h2,
    term_110 = 3'h3
  } termination_e;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic excess_zero_definition;
    counted_error_e counted_error;
    logic counter_report_mode;
    logic counter_hold;
    logic tx_external;
    logic [2:0] tx_term;
    logic rx_external;
    logic [2:0] rx_term;
  } line_ctrl_s;

  typedef struct packed {
    logic violation_pulse;
    logic pattern_error_pulse;
  } insert_s;

endpackage : liu_maint_pkg

/* File: liu_maint_term_irq_regs.sv */
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module liu_maint_term_irq_regs
  import liu_maint_pkg::*;
#(
  parameter int addr_width = 10
)
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // avalon-mm slave
  input wire logic [addr_width-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // line status inputs, bit 6 loopback activate .. bit 0 signal loss
  input wire logic [num_events-1:0] i_status,
  // controls to the line datapath
  output line_ctrl_s o_line_ctrl,
  output insert_s o_insert,
  // interrupt request
  output logic o_irq
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // one wait state: reads are captured on the first edge, writes land on
  // the edge where waitrequest is seen low, so each strobe fires once
  logic ack_reg;
  logic ack_next;
  logic wait_reg;
  wire logic request = i_read | i_write;
  wire logic [7:0] reg_index = i_address[9:2];
  wire logic word_ok = (i_address[1:0] == 2'h0);
  wire logic wr_stb = i_write & ack_reg & i_byteenable[0] & word_ok;
  wire logic rd_stb = i_read & ~ack_reg;
  wire logic wr_maint = wr_stb & (reg_index == maintenance_control_six_idx);
  wire logic wr_term = wr_stb & (reg_index == line_termination_config_idx);
  wire logic wr_mask = wr_stb & (reg_index == interrupt_mask_zero_idx);
  wire logic wr_edge = wr_stb & (reg_index == event_edge_select_idx);
  wire logic wr_pend = wr_stb & (reg_index == event_pending_idx);
  assign ack_next = request & ~ack_reg;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] maint_reg;
  logic [7:0] term_reg;
  logic [7:0] mask_reg;
  logic [7:0] edge_reg;
  logic [num_events-1:0] pend_reg;
  logic [num_events-1:0] pend_next;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      maint_reg <= maint_reset;
      term_reg <= term_reset;
      mask_reg <= mask_reset;
      edge_reg <= edge_reset;
    end
    else
    begin
      if (wr_maint)
        maint_reg <= {1'b0, i_writedata[6:0]};
      if (wr_term)
        term_reg <= {2'h0, i_writedata[5:0]};
      if (wr_mask)
        mask_reg <= {1'b0, i_writedata[6:0]};
      if (wr_edge)
        edge_reg <= {1'b0, i_writedata[6:0]};
    end
  end

  // ----------------------------------------------------------------
  // status synchronisers and event detection
  // ----------------------------------------------------------------
  // status comes from other clocks; three stages, change taken once
  // stages two and three agree
  logic [num_events-1:0] sync1_reg;
  logic [num_events-1:0] sync2_reg;
  logic [num_events-1:0] sync3_reg;
  logic [num_events-1:0] stat_reg;
  logic [num_events-1:0] stat_next;
  wire logic [num_events-1:0] agree = ~(sync2_reg ^ sync3_reg);
  assign stat_next = (agree & sync3_reg) | (~agree & stat_reg);
  wire logic [num_events-1:0] rise = stat_next & ~stat_reg;
  wire logic [num_events-1:0] fall = ~stat_next & stat_reg;
  wire logic [num_events-1:0] event_hit =
    rise | (fall & edge_reg[num_events-1:0]);
  // write one to clear; a new event in the same cycle wins
  assign pend_next = (pend_reg & ~({num_events{wr_pend}} & i_writedata[num_events-1:0]))
    | event_hit;

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      stat_reg <= '0;
      pend_reg <= '0;
    end
    else
    begin
      sync1_reg <= i_status;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      stat_reg <= stat_next;
      pend_reg <= pend_next;
    end
  end

  // ----------------------------------------------------------------
  // interrupt gating
  // ----------------------------------------------------------------
  // each bit gated by its own mask bit, one per event
  wire logic [num_events-1:0] gated = pend_next & mask_reg[num_events-1:0];
  logic irq_reg;

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      irq_reg <= 1'b0;
    else
      irq_reg <= |gated;
  end
  assign o_irq = irq_reg;

  // ----------------------------------------------------------------
  // single-shot insertion
  // ----------------------------------------------------------------
  // the bit is registered, so a level held high makes no further pulse
  logic [1:0] ins_prev_reg;
  insert_s insert_reg;
  insert_s insert_next;
  assign insert_next.violation_pulse =
    maint_reg[violation_insert_bit] & ~ins_prev_reg[1];
  assign insert_next.pattern_error_pulse =
    maint_reg[pattern_error_insert_bit] & ~ins_prev_reg[0];

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      ins_prev_reg <= 2'h0;
      insert_reg <= '0;
    end
    else
    begin
      ins_prev_reg <= {maint_reg[violation_insert_bit], maint_reg[pattern_error_insert_bit]};
      insert_reg <= insert_next;
    end
  end
  assign o_insert = insert_reg;

  // ----------------------------------------------------------------
  // line controls
  // ----------------------------------------------------------------
  line_ctrl_s ctrl_reg;
  line_ctrl_s ctrl_next;
  assign ctrl_next.excess_zero_definition = maint_reg[excess_zero_definition_bit];
  assign ctrl_next.counted_error =
    counted_error_e'(maint_reg[counted_error_lsb +: 2]);
  assign ctrl_next.counter_report_mode = maint_reg[counter_report_mode_bit];
  assign ctrl_next.counter_hold = maint_reg[counter_hold_bit];
  assign ctrl_next.tx_external = term_reg[tx_term_lsb + 2];
  assign ctrl_next.tx_term = term_reg[tx_term_lsb +: 3];
  assign ctrl_next.rx_external = term_reg[rx_term_lsb + 2];
  assign ctrl_next.rx_term = term_reg[rx_term_lsb +: 3];

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      ctrl_reg <= '0;
    else
      ctrl_reg <= ctrl_next;
  end
  assign o_line_ctrl = ctrl_reg;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // unmapped addresses read zero and still complete
  always_comb
  begin
    readdata_next = 32'h0;
    if (rd_stb && word_ok)
    begin
      unique case (reg_index)
        maintenance_control_six_idx: readdata_next = {24'h0, maint_reg};
        line_termination_config_idx: readdata_next = {24'h0, term_reg};
        interrupt_mask_zero_idx: readdata_next = {24'h0, mask_reg};
        event_edge_select_idx: readdata_next = {24'h0, edge_reg};
        event_status_idx: readdata_next = {25'h0, stat_reg};
        event_pending_idx: readdata_next = {25'h0, pend_reg};
        default: readdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      ack_reg <= 1'b0;
      wait_reg <= 1'b1;
      readdata_reg <= 32'h0;
    end
    else
    begin
      ack_reg <= ack_next;
      wait_reg <= ~ack_next;
      if (rd_stb)
        readdata_reg <= readdata_next;
    end
  end
  assign o_readdata = readdata_reg;
  // waitrequest is high until the ack cycle; reads as high while idle
  assign o_waitrequest = wait_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence viol_rise_s;
    !maint_reg[violation_insert_bit] ##1 maint_reg[violation_insert_bit];
  endsequence

  sequence err_rise_s;
    !maint_reg[pattern_error_insert_bit] ##1 maint_reg[pattern_error_insert_bit];
  endsequence

  viol_pulse_a: assert property (@(posedge i_clock) disable iff (i_rst)
    viol_rise_s |=> o_insert.violation_pulse ##1 !o_insert.violation_pulse)
    else $error("violation insert pulse missing");

  viol_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
    maint_reg[violation_insert_bit][*2] |=> !o_insert.violation_pulse)
    else $error("violation repeated while held");

  err_pulse_a: assert property (@(posedge i_clock) disable iff (i_rst)
    err_rise_s |=> o_insert.pattern_error_pulse)
    else $error("pattern error pulse missing");

  err_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
    maint_reg[pattern_error_insert_bit][*2] |=> !o_insert.pattern_error_pulse)
    else $error("pattern error repeated while held");

  tx_term_a: assert property (@(posedge i_clock) disable iff (i_rst)
    wr_term |=> ##1 o_line_ctrl.tx_term == $past(i_writedata[5:3], 2))
    else $error("transmit termination not applied");

  mask_gate_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (pend_next[0] && mask_reg[0]) |=> o_irq)
    else $error("signal loss interrupt not raised");

  masked_quiet_a: assert property (@(posedge i_clock) disable iff (i_rst)
    ((pend_next & mask_reg[num_events-1:0]) == '0) |=> !o_irq)
    else $error("masked event raised interrupt");

  fall_event_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (fall[0] && !edge_reg[0] && !pend_reg[0]) |=> !pend_reg[0])
    else $error("falling edge counted without edge select");

  mask_reset_a: assert property (@(posedge i_clock) disable iff (i_rst)
    $fell(i_rst) |-> mask_reg == 8'h00)
    else $error("mask not clear after reset");

  wait_one_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low for more than one cycle");

  write_edge_a: assert property (@(posedge i_clock) disable iff (i_rst)
    wr_stb |-> !o_waitrequest)
    else $error("write landed while waitrequest high");

  zero_def_a: assert property (@(posedge i_clock) disable iff (i_rst)
    wr_maint |=> ##1 o_line_ctrl.excess_zero_definition == $past(i_writedata[4], 2))
    else $error("excess zero definition not applied");

  counted_sel_a: assert property (@(posedge i_clock) disable iff (i_rst)
    wr_maint |=> ##1 o_line_ctrl.counted_error == $past(i_writedata[3:2], 2))
    else $error("counted error select not applied");

  report_mode_a: assert property (@(posedge i_clock) disable iff (i_rst)
    wr_maint |=> ##1 o_line_ctrl.counter_report_mode == $past(i_writedata[1], 2))
    else $error("counter report mode not applied");

  hold_bit_a: assert property (@(posedge i_clock) disable iff (i_rst)
    wr_maint |=> ##1 o_line_ctrl.counter_hold == $past(i_writedata[0], 2))
    else $error("counter hold not applied");

  tx_ext_a: assert property (@(posedge i_clock) disable iff (i_rst)
    wr_term |=> ##1 o_line_ctrl.tx_external == $past(i_writedata[5], 2))
    else $error("transmit external select not applied");

  rx_term_a: assert property (@(posedge i_clock) disable iff (i_rst)
    wr_term |=> ##1 o_line_ctrl.rx_term == $past(i_writedata[2:0], 2))
    else $error("receive termination not applied");

  rx_ext_a: assert property (@(posedge i_clock) disable iff (i_rst)
    wr_term |=> ##1 o_line_ctrl.rx_external == $past(i_writedata[2], 2))
    else $error("receive external select not applied");

  loop_act_irq_a: assert property (@(posedge i_clock) disable iff (i_rst)
    ($rose(stat_reg[6]) && $past(mask_reg[6])) |-> o_irq)
    else $error("loopback activate interrupt not raised");

  loop_deact_irq_a: assert property (@(posedge i_clock) disable iff (i_rst)
    ($rose(stat_reg[5]) && $past(mask_reg[5])) |-> o_irq)
    else $error("loopback deactivate interrupt not raised");

  sync_irq_a: assert property (@(posedge i_clock) disable iff (i_rst)
    ($rose(stat_reg[4]) && $past(mask_reg[4])) |-> o_irq)
    else $error("pattern sync interrupt not raised");

  clock_loss_irq_a: assert property (@(posedge i_clock) disable iff (i_rst)
    ($rose(stat_reg[3]) && $past(mask_reg[3])) |-> o_irq)
    else $error("transmit clock loss interrupt not raised");

  drive_fail_irq_a: assert property (@(posedge i_clock) disable iff (i_rst)
    ($rose(stat_reg[2]) && $past(mask_reg[2])) |-> o_irq)
    else $error("driver failure interrupt not raised");

  alarm_irq_a: assert property (@(posedge i_clock) disable iff (i_rst)
    ($rose(stat_reg[1]) && $past(mask_reg[1])) |-> o_irq)
    else $error("alarm indication interrupt not raised");

  fall_both_a: assert property (@(posedge i_clock) disable iff (i_rst)
    ($fell(stat_reg[0]) && $past(edge_reg[0]) && $past(mask_reg[0])) |-> o_irq)
    else $error("falling edge not counted with edge select");

  pend_set_a: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(stat_reg[0]) |-> pend_reg[0])
    else $error("rising status not recorded as pending");

  sync_agree_a: assert property (@(posedge i_clock) disable iff (i_rst)
    $changed(stat_reg[0]) |-> $past(sync2_reg[0]) == $past(sync3_reg[0]))
    else $error("status taken before synchroniser stages agreed");

endmodule // liu_maint_term_irq_regs

`default_nettype wire

/* File: liu_maint_term_irq_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module liu_maint_term_irq_regs_tb;
  import liu_maint_pkg::*;

  localparam logic [9:0] a_maint = {maintenance_control_six_idx, 2'b00};
  localparam logic [9:0] a_term = {line_termination_config_idx, 2'b00};
  localparam logic [9:0] a_mask = {interrupt_mask_zero_idx, 2'b00};
  localparam logic [9:0] a_edge = {event_edge_select_idx, 2'b00};
  localparam logic [9:0] a_pend = {event_pending_idx, 2'b00};

  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [9:0] i_address = '0;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = '0;
  logic [3:0] i_byteenable = '0;
  logic [6:0] i_status = '0;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  line_ctrl_s o_line_ctrl;
  insert_s o_insert;
  logic o_irq;
  int err_count = 0;
  int n_compared = 0;
  int ins_n[2] = '{0, 0};
  logic [31:0] exp_q[$];

  liu_maint_term_irq_regs #(.addr_width(10)) i_dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_status(i_status),
    .o_line_ctrl(o_line_ctrl), .o_insert(o_insert), .o_irq(o_irq)
  );

  initial
  begin
    forever #10 i_clock = ~i_clock;
  end

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // waits for the single wait state to end, bounded so a dead slave is caught
  task automatic wait_ack();
    int n;
    n = 0;
    do
    begin
      @(posedge i_clock);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      chk(1'b0, 1'b1, "waitrequest never dropped");
  endtask

  task automatic bus_write(input logic [9:0] a, input logic [7:0] d,
                           input logic [3:0] be = 4'hf);
    @(posedge i_clock);
    i_address <= a;
    i_writedata <= {24'h000000, d};
    i_byteenable <= be;
    i_write <= 1'b1;
    wait_ack();
    i_write <= 1'b0;
  endtask

  task automatic bus_read(input logic [9:0] a, input logic [7:0] exp);
    exp_q.push_back({24'h000000, exp});
    @(posedge i_clock);
    i_address <= a;
    i_read <= 1'b1;
    wait_ack();
    i_read <= 1'b0;
  endtask

  task automatic chk_line(input logic [7:0] m, input logic [7:0] t);
    repeat (3) @(posedge i_clock);
    chk(o_line_ctrl.excess_zero_definition, m[4], "excess_zero_definition");
    chk(o_line_ctrl.counted_error, m[3:2], "counted error");
    chk(o_line_ctrl.counter_report_mode, m[1], "report mode");
    chk(o_line_ctrl.counter_hold, m[0], "hold");
    chk(o_line_ctrl.tx_term[1:0], t[4:3], "tx term");
    chk(o_line_ctrl.tx_external, t[5], "tx external");
    chk({o_line_ctrl.rx_external, o_line_ctrl.rx_term[1:0]}, t[2:0], "rx term");
  endtask

  // status is synchronised over several edges, so eight cycles cover sync plus irq flop
  task automatic irq_step(input int n, input logic lvl, input logic exp);
    @(posedge i_clock);
    i_status[n] <= lvl;
    repeat (8) @(posedge i_clock);
    chk(o_irq, exp, "irq level");
  endtask

  // ----------------------------------------------------------------
  // result monitor
  // ----------------------------------------------------------------
  always @(posedge i_clock)
  begin
    if (o_insert.pattern_error_pulse === 1'b1)
      ins_n[0]++;
    if (o_insert.violation_pulse === 1'b1)
      ins_n[1]++;
    if (i_read === 1'b1 && o_waitrequest === 1'b0)
    begin
      if (exp_q.size() == 0)
        chk(1'b0, 1'b1, "unexpected read answer");
      else
        chk(o_readdata, exp_q.pop_front(), "read data");
    end
  end

  initial
  begin
    repeat (20000) @(posedge i_clock);
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    logic [7:0] m;
    logic [7:0] t;
    void'($urandom(68223));
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    bus_read(a_maint, maint_reset);
    bus_read(a_term, term_reset);
    bus_read(a_mask, 8'h00);
    bus_read(10'h0d0, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      r = $urandom;
      m = {3'b000, r[0], k[1:0], r[2:1]};
      t = {2'b00, k[2:0], 3'(7 - k)};
      bus_write(a_maint, m | 8'h80);
      bus_write(a_term, t | 8'hc0);
      bus_write(a_mask, r[15:8]);
      bus_read(a_maint, m);
      bus_read(a_term, t);
      bus_read(a_mask, {1'b0, r[14:8]});
      chk_line(m, t);
    end
    // ignored writes: no byte lane, misaligned address
    bus_write(a_maint, 8'h1f, 4'h0);
    bus_write(a_maint | 10'h001, 8'h1f);
    bus_read(a_maint, m);
    for (int b = 0; b < 2; b++)
    begin
      m = b ? 8'h40 : 8'h20;
      bus_write(a_maint, 8'h00);
      repeat (4) @(posedge i_clock);
      ins_n = '{0, 0};
      bus_write(a_maint, m);
      bus_write(a_maint, m | 8'h01);
      bus_write(a_maint, m);
      repeat (4) @(posedge i_clock);
      chk(ins_n[b], 1, "one insert per rise");
      bus_write(a_maint, 8'h00);
      bus_write(a_maint, m);
      repeat (4) @(posedge i_clock);
      chk(ins_n[b], 2, "insert after re-arm");
      chk(ins_n[1 - b], 0, "other insert quiet");
    end
    for (int n = 0; n < 7; n++)
    begin
      bus_write(a_mask, 8'h00);
      bus_write(a_edge, 8'h00);
      bus_write(a_pend, 8'h7f);
      irq_step(n, 1'b1, 1'b0);
      irq_step(n, 1'b0, 1'b0);
      bus_write(a_pend, 8'h7f);
      bus_write(a_mask, 8'(1 << n));
      irq_step(n, 1'b1, 1'b1);
      bus_write(a_pend, 8'h7f);
      repeat (3) @(posedge i_clock);
      chk(o_irq, 1'b0, "irq after clear");
      irq_step(n, 1'b0, 1'b0);
      bus_write(a_edge, 8'(1 << n));
      irq_step(n, 1'b1, 1'b1);
      bus_write(a_pend, 8'h7f);
      irq_step(n, 1'b0, 1'b1);
      bus_write(a_pend, 8'h7f);
    end
    tally_and_finish();
  end
endmodule // liu_maint_term_irq_regs_tb

`default_nettype wire
